// file: rtl/esd_consts.svh
// constants of the external bus space decoder
//
// =====================================================================
// Overview of operation
// R01: four external select areas, area 0 up to 2 Mbytes, areas 1-3 up to 4 Mbytes each.
// R02: each external area has its own software wait count of zero to three.
// R03: while the wait request input is active the external cycle is stretched.
// R04: addresses are 32 bits and the top eight bits never reach the pins.
// R05: bits 23:22 pick one of four selects, only when bits 31:24 are zero.
// R06: bits 21:0 are driven on the external address pins during external cycles.
// R07: areas sit at 0x00200000, 0x00400000, 0x00800000, 0x00c00000, all byte wide.
// R08: software keeps away from reserved regions; behaviour there is not promised.
// R09: the bus size register resets to 0x200f and keeps its contents in standby.
// R10: bits 15, 14 and 12:4 of the bus size register read zero and are written zero.
// R11: bit 13 of the bus size register reads one and is written one.
// R12: software never writes ones into bits 7:4 of the bus size register.
// R13: bits 3:0 give the bus size of areas 3:0, zero byte, one word, reset one.
// R14: software clears every area bus size bit, as only a byte bus exists.
// R15: software sets the bus sizes once after reset before touching any area.
// R16: a 32-bit on-chip RAM access completes in a single state.
// R17: at most one select is low, read strobe only in reads, write strobe in writes.
`ifndef ESD_CONSTS_SVH
`define ESD_CONSTS_SVH

// =====================================================================
// register offsets and reset values
`define ESD_REG_ABSC 32'hffff8620
`define ESD_REG_IDLE 32'hffff8622
`define ESD_REG_WAIT 32'hffff8624
`define ESD_ABSC_RESET 16'h200f
`define ESD_ABSC_FIXED 16'h2000
`define ESD_ABSC_SZ_RESET 4'hf
`define ESD_IDLE_RESET 16'hffff
`define ESD_WAIT_RESET 16'hffff

// =====================================================================
// field positions
`define ESD_IDLE_CW_LSB 4
`define ESD_IDLE_SW_LSB 0

// =====================================================================
// address map
`define ESD_TOP_SEL_MSB 31
`define ESD_TOP_SEL_LSB 24
`define ESD_AREA_MSB 23
`define ESD_AREA_LSB 22
`define ESD_EXT_ADDR_W 22
`define ESD_ROM_END 32'h00027fff
`define ESD_AREA0_BASE 32'h00200000
`define ESD_PERI_BASE 32'hffff8000
`define ESD_PERI_END 32'hffff87ff
`define ESD_RAM_BASE 32'hfffff000
`define ESD_RAM_WORDS 1024

`endif

// file: rtl/esd_pkg.sv
// types shared by the external bus space decoder
package esd_pkg;

  // =====================================================================
  // space kinds, request, answer and pin groups
  typedef enum logic [3:0] {
    ESD_SP_EXT = 4'h1,
    ESD_SP_RAM = 4'h2,
    ESD_SP_OTHER = 4'h4,
    ESD_SP_RSVD = 4'h8
  } esd_space_t;

  typedef enum logic [4:0] {
    ESD_ST_IDLE = 5'h01,
    ESD_ST_SETUP = 5'h02,
    ESD_ST_ACCESS = 5'h04,
    ESD_ST_HOLD = 5'h08,
    ESD_ST_GAP = 5'h10
  } esd_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [31:0] wdata;
    logic [3:0] be;
  } esd_req_t;

  typedef struct packed {
    logic done;
    logic err;
    logic [31:0] rdata;
  } esd_resp_t;

  typedef struct packed {
    logic [3:0] area_select_n;
    logic read_strobe_n;
    logic write_strobe_n;
    logic [21:0] addr;
    logic [7:0] data_out;
    logic data_oe;
  } esd_ext_out_t;

endpackage

// file: rtl/esd_space_decode.sv
// address space decoder for the external bus controller
`timescale 1ns/1ps
`default_nettype none
`include "esd_consts.svh"
module esd_space_decode (
  // address in
  input wire logic [31:0] addr,
  // decode out
  output esd_pkg::esd_space_t space,
  output logic [1:0] area
);
  import esd_pkg::*;

  // R05 area from bits 23:22
  assign area = addr[`ESD_AREA_MSB:`ESD_AREA_LSB];

  always_comb begin
    space = ESD_SP_RSVD;
    // R05 selects only when top byte is zero
    if (addr[`ESD_TOP_SEL_MSB:`ESD_TOP_SEL_LSB] == 8'h00) begin
      // R07 area 0 starts at 2 Mbytes
      if (addr >= `ESD_AREA0_BASE) begin
        space = ESD_SP_EXT;
      end else if (addr <= `ESD_ROM_END) begin
        space = ESD_SP_OTHER;
      end
    end else if (addr >= `ESD_RAM_BASE) begin
      space = ESD_SP_RAM;
    end else if (addr >= `ESD_PERI_BASE && addr <= `ESD_PERI_END) begin
      space = ESD_SP_OTHER;
    end
  end

endmodule
`default_nettype wire

// file: rtl/esd_onchip_ram.sv
// on-chip RAM with single state 32-bit access
`timescale 1ns/1ps
`default_nettype none
module esd_onchip_ram #(
  parameter int WORDS = 1024,
  parameter int AW = $clog2(WORDS)
) (
  // clock
  input wire logic sys_clk,
  input wire logic ce,
  // access port
  input wire logic en,
  input wire logic we,
  input wire logic [3:0] be,
  input wire logic [AW-1:0] index,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata
);
  logic [31:0] mem [WORDS];
  logic [31:0] q;

  // R16 whole word in one state
  always_ff @(posedge sys_clk) begin
    if (ce && en) begin
      for (int b = 0; b < 4; b++) begin
        if (we && be[b]) begin
          mem[index][8*b +: 8] <= wdata[8*b +: 8];
        end
      end
      q <= mem[index];
    end
  end

  assign rdata = q;

endmodule
`default_nettype wire

// file: rtl/esd_external_bus_controller.sv
// external bus controller: space decode, area selects and control registers
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "esd_consts.svh"
module esd_external_bus_controller #(
  parameter int RAM_WORDS = `ESD_RAM_WORDS
) (
  // clock, reset and enable
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  // register port
  input wire logic [31:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // processor request
  input wire logic req_valid,
  input wire esd_pkg::esd_req_t req,
  output logic req_ready,
  output esd_pkg::esd_resp_t resp,
  // external bus
  output esd_pkg::esd_ext_out_t ext,
  input wire logic [7:0] ext_data_in,
  input wire logic ext_wait_n,
  // status
  output logic [3:0] area_bus_size
);
  import esd_pkg::*;

  localparam int RAW = $clog2(RAM_WORDS);

  // =====================================================================
  // state
  typedef struct packed {
    esd_state_t fsm;
    logic [3:0] sz;
    logic [15:0] idle_ctl;
    logic [15:0] wait_ctl;
    logic [15:0] rdata;
    logic [1:0] area;
    logic write;
    logic [21:0] addr;
    logic [7:0] wdata;
    logic [1:0] wcnt;
    logic [1:0] gcnt;
    logic ram_pending;
    esd_ext_out_t ext;
    esd_resp_t resp;
  } esd_ctl_t;

  esd_ctl_t r;
  esd_ctl_t next_r;

  esd_space_t space;
  logic [1:0] req_area;
  logic [31:0] ram_q;
  logic ram_en;
  logic take;

  // =====================================================================
  // helpers
  function automatic logic [1:0] esd_pick2(input logic [15:0] v,
                                          input logic [3:0] lsb);
    esd_pick2 = v[lsb +: 2];
  endfunction

  function automatic logic [1:0] esd_max2(input logic [1:0] a,
                                         input logic [1:0] b);
    esd_max2 = (a > b) ? a : b;
  endfunction

  // =====================================================================
  // decode and on-chip RAM
  esd_space_decode u_decode (
    .addr(req.addr),
    .space(space),
    .area(req_area)
  );

  assign req_ready = (r.fsm == ESD_ST_IDLE);
  assign take = req_valid && req_ready;
  assign ram_en = take && (space == ESD_SP_RAM);

  // R16 RAM answered one state after request
  esd_onchip_ram #(
    .WORDS(RAM_WORDS),
    .AW(RAW)
  ) u_ram (
    .sys_clk(sys_clk),
    .ce(ce),
    .en(ram_en),
    .we(req.write),
    .be(req.be),
    .index(req.addr[RAW+1:2]),
    .wdata(req.wdata),
    .rdata(ram_q)
  );

  // =====================================================================
  // next state
  always_comb begin
    logic [1:0] gap;
    logic sw;
    gap = 2'h0;
    sw = 1'b0;
    next_r = r;
    next_r.resp.done = 1'b0;
    next_r.resp.err = 1'b0;
    next_r.ram_pending = 1'b0;
    next_r.rdata = 16'h0000;

    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        `ESD_REG_ABSC: begin
          // R13 only the size bits are stored
          // R12 bits 7:4 are dropped on write
          next_r.sz = reg_wdata[3:0];
        end
        `ESD_REG_IDLE: begin
          next_r.idle_ctl = reg_wdata;
        end
        `ESD_REG_WAIT: begin
          next_r.wait_ctl = reg_wdata;
        end
        default: begin
        end
      endcase
    end

    // register reads, answered next cycle
    if (reg_rd) begin
      unique case (reg_addr)
        `ESD_REG_ABSC: begin
          // R10 reserved bits read zero
          // R11 bit 13 reads one
          next_r.rdata = `ESD_ABSC_FIXED | {12'h000, r.sz};
        end
        `ESD_REG_IDLE: begin
          next_r.rdata = r.idle_ctl;
        end
        `ESD_REG_WAIT: begin
          next_r.rdata = r.wait_ctl;
        end
        default: begin
          next_r.rdata = 16'h0000;
        end
      endcase
    end

    sw = r.idle_ctl[`ESD_IDLE_SW_LSB + r.area];

    unique case (r.fsm)
      ESD_ST_IDLE: begin
        if (req_valid) begin
          unique case (space)
            ESD_SP_EXT: begin
              next_r.area = req_area;
              next_r.write = req.write;
              // R04 top byte kept off the pins
              // R06 low 22 bits go out
              next_r.addr = req.addr[`ESD_EXT_ADDR_W-1:0];
              // R07 byte bus, low lane only
              next_r.wdata = req.wdata[7:0];
              // R02 per-area software waits
              next_r.wcnt = esd_pick2(r.wait_ctl, {req_area, 2'b00});
              if (r.idle_ctl[`ESD_IDLE_SW_LSB + req_area]) begin
                next_r.fsm = ESD_ST_SETUP;
              end else begin
                next_r.fsm = ESD_ST_ACCESS;
              end
            end
            ESD_SP_RAM: begin
              // R16 single state answer
              next_r.ram_pending = 1'b1;
              next_r.resp.done = 1'b1;
            end
            ESD_SP_OTHER: begin
              next_r.resp.done = 1'b1;
              next_r.resp.rdata = 32'h00000000;
            end
            ESD_SP_RSVD: begin
              // R08 reserved access flagged, nothing driven
              next_r.resp.done = 1'b1;
              next_r.resp.err = 1'b1;
              next_r.resp.rdata = 32'h00000000;
            end
            default: begin
              next_r.resp.done = 1'b1;
              next_r.resp.err = 1'b1;
            end
          endcase
        end
      end
      ESD_ST_SETUP: begin
        next_r.fsm = ESD_ST_ACCESS;
      end
      ESD_ST_ACCESS: begin
        if (r.wcnt != 2'h0) begin
          // R02 count software waits down
          next_r.wcnt = r.wcnt - 2'h1;
        end else if (ext_wait_n) begin
          next_r.resp.done = 1'b1;
          next_r.resp.rdata = r.write ? 32'h00000000 :
                              {24'h000000, ext_data_in};
          gap = r.idle_ctl[`ESD_IDLE_CW_LSB + r.area] ? 2'h1 : 2'h0;
          if (!r.write) begin
            gap = esd_max2(gap,
                           esd_pick2(r.idle_ctl, {1'b1, r.area, 1'b0}));
          end
          next_r.gcnt = gap;
          if (sw) begin
            next_r.fsm = ESD_ST_HOLD;
          end else if (gap != 2'h0) begin
            next_r.fsm = ESD_ST_GAP;
          end else begin
            next_r.fsm = ESD_ST_IDLE;
          end
        end
        // R03 wait pin low holds the access state
      end
      ESD_ST_HOLD: begin
        if (r.gcnt != 2'h0) begin
          next_r.fsm = ESD_ST_GAP;
        end else begin
          next_r.fsm = ESD_ST_IDLE;
        end
      end
      ESD_ST_GAP: begin
        next_r.gcnt = r.gcnt - 2'h1;
        if (r.gcnt <= 2'h1) begin
          next_r.fsm = ESD_ST_IDLE;
        end
      end
    endcase

    // pins follow the next state so they leave flip-flops
    next_r.ext.area_select_n = 4'hf;
    next_r.ext.read_strobe_n = 1'b1;
    next_r.ext.write_strobe_n = 1'b1;
    next_r.ext.data_oe = 1'b0;
    next_r.ext.addr = next_r.addr;
    next_r.ext.data_out = next_r.wdata;
    if (next_r.fsm inside {ESD_ST_SETUP, ESD_ST_ACCESS, ESD_ST_HOLD}) begin
      // R01 one of four areas
      // R17 only one select low
      next_r.ext.area_select_n[next_r.area] = 1'b0;
      // write data held across the extension cycles
      next_r.ext.data_oe = next_r.write;
    end
    if (next_r.fsm == ESD_ST_ACCESS) begin
      // R17 strobe matches direction
      next_r.ext.read_strobe_n = next_r.write;
      next_r.ext.write_strobe_n = !next_r.write;
    end
  end

  // =====================================================================
  // registers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      r <= '0;
      r.fsm <= ESD_ST_IDLE;
      // R09 power-on values
      r.sz <= `ESD_ABSC_SZ_RESET;
      r.idle_ctl <= `ESD_IDLE_RESET;
      r.wait_ctl <= `ESD_WAIT_RESET;
      r.ext.area_select_n <= 4'hf;
      r.ext.read_strobe_n <= 1'b1;
      r.ext.write_strobe_n <= 1'b1;
    end else if (ce) begin
      // R09 standby holds ce low, contents kept
      r <= next_r;
    end
  end

  // =====================================================================
  // outputs
  assign reg_rdata = r.rdata;
  assign ext = r.ext;
  // R14 size bits are reported only, the bus stays byte wide
  assign area_bus_size = r.sz;
  assign resp.done = r.resp.done;
  assign resp.err = r.resp.err;
  assign resp.rdata = r.ram_pending ? ram_q : r.resp.rdata;

endmodule
`default_nettype wire

// file: verification/esd_ext_mem_model.sv
// byte wide external memory standing on the area select bus
`timescale 1ns/1ps
`default_nettype none
module esd_ext_mem_model (
  // bus pins
  input wire logic sys_clk,
  input wire esd_pkg::esd_ext_out_t ext,
  output logic [7:0] ext_data_in,
  output logic ext_wait_n,
  // wait request length set by the bench
  input wire logic [3:0] stall
);
  import esd_pkg::*;
  logic [7:0] mem [0:255];
  logic [7:0] last = 8'h00;
  logic [3:0] cnt = 4'h0;
  logic act;
  // =====================================================================
  // pins
  assign act = (ext.area_select_n != 4'hf) &&
    !(ext.read_strobe_n && ext.write_strobe_n);
  assign ext_wait_n = !(act && (cnt < stall));
  // released bus shows the inverse so a stale byte never matches
  assign ext_data_in = !ext.read_strobe_n ? mem[ext.addr[7:0]] : ~last;
  always_ff @(posedge sys_clk) begin
    cnt <= act ? cnt + 4'h1 : 4'h0;
    if (!ext.read_strobe_n) begin
      last <= mem[ext.addr[7:0]];
    end
    if (!ext.write_strobe_n && ext.data_oe) begin
      mem[ext.addr[7:0]] <= ext.data_out;
    end
  end
endmodule
`default_nettype wire

// file: verification/esd_ebc_chk.sv
// port checker of the external bus controller
`timescale 1ns/1ps
`default_nettype none
`include "esd_consts.svh"
module esd_ebc_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  // register port
  input wire logic [31:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // request and bus
  input wire logic req_valid,
  input wire esd_pkg::esd_req_t req,
  input wire logic req_ready,
  input wire esd_pkg::esd_resp_t resp,
  input wire esd_pkg::esd_ext_out_t ext,
  input wire logic ext_wait_n,
  input wire logic [3:0] area_bus_size
);
  import esd_pkg::*;
  logic last_wr;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // =====================================================================
  // direction of the cycle in flight, since req may change after accept
  always_ff @(posedge sys_clk) begin
    if (req_valid && req_ready && ce) begin
      last_wr <= req.write;
    end
  end
  sequence s_take;
    req_valid && req_ready && ce;
  endsequence
  sequence s_ext;
    s_take ##0 (req.addr[31:24] == 8'h00 && req.addr[23:21] != 3'h0);
  endsequence
  // =====================================================================
  // assertions
  a_reset_load: assert property ($rose(nrst) |->
    area_bus_size == 4'hf && ext.area_select_n == 4'hf)
    else $error("reset values wrong");
  a_fixed_bits: assert property (reg_rd && ce &&
    reg_addr == `ESD_REG_ABSC |=> reg_rdata[15:4] == 12'h200)
    else $error("fixed size bits wrong");
  a_size_mirror: assert property (reg_wr && ce &&
    reg_addr == `ESD_REG_ABSC |=> area_bus_size == $past(reg_wdata[3:0]))
    else $error("size bits not stored");
  a_ext_decode: assert property (s_ext |=>
    ext.area_select_n == ~(4'h1 << $past(req.addr[23:22])) &&
    ext.addr == $past(req.addr[21:0]))
    else $error("area decode wrong");
  a_top_quiet: assert property (s_take ##0 req.addr[31:24] != 8'h00
    |=> (ext.area_select_n == 4'hf)[*2])
    else $error("select outside external space");
  a_ram_single: assert property (s_take ##0
    req.addr[31:12] == 20'hfffff |=> resp.done && !resp.err)
    else $error("ram access not single state");
  a_wait_hold: assert property ((!ext.read_strobe_n ||
    !ext.write_strobe_n) && !ext_wait_n |=> !resp.done)
    else $error("wait request ignored");
  a_one_select: assert property ($countones(~ext.area_select_n) <= 1)
    else $error("two selects low");
  a_read_dir: assert property (!ext.read_strobe_n |->
    !last_wr && ext.area_select_n != 4'hf)
    else $error("read strobe out of read");
  a_write_dir: assert property (!ext.write_strobe_n |->
    last_wr && ext.read_strobe_n && ext.area_select_n != 4'hf)
    else $error("write strobe out of write");
endmodule
bind esd_external_bus_controller esd_ebc_chk u_chk (
  .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .resp(resp), .ext(ext), .ext_wait_n(ext_wait_n),
  .area_bus_size(area_bus_size)
);
`default_nettype wire

// file: verification/test_external_bus_space_decoder.sv
// self-checking bench of the external bus controller
`timescale 1ns/1ps
`default_nettype none
`include "esd_consts.svh"
module test_external_bus_space_decoder;
  import esd_pkg::*;
  logic sys_clk, nrst, ce, reg_wr, reg_rd, req_valid, req_ready, ext_wait_n;
  logic [31:0] reg_addr, a, w32;
  logic [15:0] reg_wdata, reg_rdata, wcfg;
  esd_req_t req;
  esd_resp_t resp;
  esd_ext_out_t ext;
  logic [7:0] ext_data_in, d;
  logic [3:0] area_bus_size, stall, sz, n;
  logic [1:0] ar;
  int n_fail, check_count, seed, lat, i;
  // =====================================================================
  // clock, design and far side
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  esd_external_bus_controller dut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .resp(resp), .ext(ext),
    .ext_data_in(ext_data_in), .ext_wait_n(ext_wait_n),
    .area_bus_size(area_bus_size));
  esd_ext_mem_model u_mem (.sys_clk(sys_clk), .ext(ext),
    .ext_data_in(ext_data_in), .ext_wait_n(ext_wait_n), .stall(stall));
  // =====================================================================
  // tasks and expectations
  task automatic conclude;
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] ad, input logic [15:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] ad, input logic [15:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk("reg_rdata", {16'h0, e}, {16'h0, reg_rdata});
  endtask
  // waits for ready, issues one request and counts cycles to done
  task automatic acc(input logic [31:0] ad, input logic w,
                     input logic [31:0] v, input logic [3:0] be);
    int k;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (req_ready !== 1'b1 && k < 60);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req <= '{ad, w, v, be};
    @(posedge sys_clk);
    req_valid <= 1'b0;
    lat = 0;
    do begin
      @(negedge sys_clk);
      lat++;
    end while (resp.done !== 1'b1 && lat < 60);
  endtask
  // pin wait counts from the first strobe cycle alongside the software waits of the area, so the longer one decides
  function automatic int exp_lat(input logic [1:0] x, input logic [3:0] p);
    int w;
    w = wcfg[4*x +: 2];
    return 2 + ((p > w) ? p : w);
  endfunction
  // =====================================================================
  // main sequence
  initial begin
    seed = 20719;
    n_fail = 0;
    check_count = 0;
    nrst = 1'b0;
    ce = 1'b1;
    {reg_wr, reg_rd, req_valid} = 3'h0;
    {reg_addr, reg_wdata} = 48'h0;
    req = '0;
    stall = 4'h0;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(`ESD_REG_ABSC, 16'h200f);
    rd(`ESD_REG_IDLE, 16'hffff);
    rd(`ESD_REG_WAIT, 16'hffff);
    rd(32'hffff8626, 16'h0000);
    for (i = 0; i < 4; i++) begin
      sz = 4'($random(seed));
      wr(`ESD_REG_ABSC, 16'h2000 | {12'h0, sz});
      rd(`ESD_REG_ABSC, 16'h2000 | {12'h0, sz});
      chk("area_bus_size", {28'h0, sz}, {28'h0, area_bus_size});
    end
    wr(`ESD_REG_ABSC, 16'h2000);
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(`ESD_REG_ABSC, 16'h200a);
    @(posedge sys_clk);
    ce <= 1'b1;
    rd(`ESD_REG_ABSC, 16'h2000);
    wr(`ESD_REG_IDLE, 16'h0000);
    wcfg = 16'($random(seed));
    wr(`ESD_REG_WAIT, wcfg);
    rd(`ESD_REG_WAIT, wcfg);
    for (i = 0; i < 12; i++) begin
      ar = 2'(i);
      // external stimulus stays inside the mapped areas
      a = {8'h00, ar, 22'($random(seed))};
      if (i < 4) a[21:0] = 22'h3fffff;
      if (ar == 2'h0) a[21] = 1'b1;
      d = 8'($random(seed));
      n = (i == 1) ? 4'h6 : 4'($random(seed)) & 4'h3;
      stall <= n;
      acc(a, 1'b1, {24'h0, d}, 4'h1);
      chk("write latency", exp_lat(ar, n), lat);
      stall <= 4'h0;
      acc(a, 1'b0, 32'h0, 4'h1);
      chk("read latency", exp_lat(ar, 4'h0), lat);
      chk("read byte", {24'h0, d}, resp.rdata);
    end
    for (i = 0; i < 4; i++) begin
      w32 = $random(seed);
      acc(`ESD_RAM_BASE + 32'(4 * i), 1'b1, w32, 4'hf);
      chk("ram write latency", 1, lat);
      acc(`ESD_RAM_BASE + 32'(4 * i), 1'b0, 32'h0, 4'hf);
      chk("ram word", w32, resp.rdata);
    end
    acc(32'h00000100, 1'b0, 32'h0, 4'h1);
    chk("rom latency", 1, lat);
    chk("rom data", 0, resp.rdata);
    // select extension on area 1 adds one setup cycle before the strobe
    wr(`ESD_REG_IDLE, 16'h0002);
    stall <= 4'h0;
    acc(32'h00400010, 1'b1, 32'h0000005a, 4'h1);
    chk("extended write latency", exp_lat(2'h1, 4'h0) + 1, lat);
    acc(32'h00400010, 1'b0, 32'h0, 4'h1);
    chk("extended read latency", exp_lat(2'h1, 4'h0) + 1, lat);
    chk("extended read byte", 32'h0000005a, resp.rdata);
    acc(32'h01000000, 1'b0, 32'h0, 4'h1);
    chk("reserved err", 1, {31'h0, resp.err});
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(`ESD_REG_ABSC, 16'h200f);
    rd(`ESD_REG_WAIT, 16'hffff);
    conclude();
  end
  // a hang is cut short well past the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    conclude();
  end
endmodule
`default_nettype wire
